/* core/packet_mode_core.v */
/*
  byte-wide hdlc packet mode of a ds3/e3 framer channel: avalon slave,
  transmit framer with stuffing and fcs, receive deframer.
  assumes the receive payload bit clock arrives on a pin; transmit bits are paced from clk; bytes are handled on clk.
*/
`timescale 1ns/100ps
`include "packet_mode_defs.vh"
// Notes on behaviour
// [RULE1] bit 6 of control register 0x82 turns packet mode on
// [RULE2] strap pin must also be held high for packet mode
// [RULE3] transmit takes whole bytes from an eight-bit bus
// [RULE4] accepted bytes are framed and sent on outbound payload bits
// [RULE5] zeros are inserted so data never mimics flag or abort
// [RULE6] optional 16 or 32 bit fcs appended as trailer
// [RULE7] idle transmit sends back-to-back flag octets
// [RULE8] receive frames are output byte by byte on eight-bit bus
// [RULE9] flags alone produce no receive bytes
// [RULE10] receiver rechecks fcs against the trailer
// [RULE11] receiver deletes stuffed zeros
// [RULE12] transmit and receive run together once mode is set
// [RULE13] send-message high latches bytes; low sends only flags
// [RULE14] send-check-sequence held two or four demand periods
// [RULE15] demand clock driven out, stalls when stuffing, falling edge samples
// [RULE16] a zero follows every five ones; receiver removes it
// [RULE17] customary hdlc polynomials, preset and complement
module packet_mode_core (
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire nibble_select_strap,
  input wire send_message_cmd,
  input wire send_check_sequence_cmd,
  input wire [7:0] tx_packet_byte_bus,
  output reg tx_packet_demand_clock,
  output reg tx_payload_bit,
  output reg tx_payload_strobe,
  input wire rx_payload_bit,
  input wire rx_payload_clock,
  output reg [7:0] rx_packet_byte_bus,
  output reg rx_packet_byte_valid,
  output reg rx_frame_end,
  output reg rx_frame_bad
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  wire [13:0] sync_q;
  sync_pair #(.W(14)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({nibble_select_strap, send_message_cmd, send_check_sequence_cmd,
        rx_payload_bit, ~rx_payload_clock, 1'b0, tx_packet_byte_bus}),
    .q(sync_q)
  );
  wire strap_s = sync_q[13];
  wire msg_s = sync_q[12];
  wire fcs_cmd_s = sync_q[11];
  wire rxd_s = sync_q[10];
  wire rxc_s = ~sync_q[9]; // synced inverted: idle high right after reset
  wire [7:0] txd_s = sync_q[7:0];

  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  reg [7:0] ctrl_reg;
  reg [3:0] stat_reg;
  reg ack_reg;
  wire mode_on = ctrl_reg[`PKT_CTRL_ON_BIT] & strap_s; // RULE1 RULE2
  wire crc_wide = ctrl_reg[`PKT_CTRL_CRC32_BIT];
  wire fcs_en = ctrl_reg[`PKT_CTRL_FCS_EN_BIT];
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `PKT_CTRL_RESET;
      ack_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      // write lands at the edge after the wait state, while waitrequest is low
      if (avs_write && ack_reg && avs_address == `PKT_CTRL_ADDR)
        ctrl_reg <= avs_writedata[7:0]; // RULE1
      if (req & ~ack_reg) begin
        if (avs_address == `PKT_CTRL_ADDR)
          avs_readdata <= {24'h000000, ctrl_reg};
        else if (avs_address == `PKT_STAT_ADDR)
          avs_readdata <= {28'h0000000, stat_reg};
        else
          avs_readdata <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit bit timing and demand clock
  // ------------------------------------------------------------
  reg [7:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == `BIT_PERIOD);
  reg [7:0] tx_sh_reg;
  reg [3:0] tx_left_reg;
  reg [2:0] tx_ones_reg;
  reg [1:0] tx_st_reg;
  reg [2:0] fcs_cnt_reg;
  reg [2:0] fcs_hold_reg;
  reg fcs_cmd_d_reg;
  reg stuff_reg;
  localparam TX_IDLE = 2'b00;
  localparam TX_DATA = 2'b01;
  localparam TX_FCS = 2'b10;
  localparam TX_CLOSE = 2'b11;
  wire [31:0] tx_crc;
  wire [31:0] tx_crc_now = crc_fold(tx_crc, cur_bit, crc_wide);
  wire cur_bit = tx_sh_reg[0];
  wire in_frame = (tx_st_reg == TX_DATA) | (tx_st_reg == TX_FCS);
  // ones count is only kept in frame; a trailer ending in five ones
  // still gets its zero before the closing flag
  wire need_stuff = (tx_ones_reg == `ONES_LIMIT); // RULE5 RULE16
  wire byte_done = tick & ~need_stuff & (tx_left_reg == 4'h1);
  wire crc_step = tick & ~need_stuff & (tx_st_reg == TX_DATA);
  wire [2:0] fcs_len = crc_wide ? `CRC32_BYTES : `CRC16_BYTES;

  fcs_engine u_tx_fcs (
    .clk(clk),
    .rst_n(rst_n),
    .init(tx_st_reg == TX_IDLE || tx_st_reg == TX_CLOSE),
    .step(crc_step),
    .din(cur_bit),
    .wide(crc_wide),
    .crc_reg(tx_crc)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 8'h00;
      tx_sh_reg <= `FLAG_OCTET;
      tx_left_reg <= 4'h8;
      tx_ones_reg <= 3'h0;
      tx_st_reg <= TX_IDLE;
      fcs_cnt_reg <= 3'h0;
      fcs_hold_reg <= 3'h0;
      fcs_cmd_d_reg <= 1'b0;
      tx_payload_bit <= 1'b1;
      tx_payload_strobe <= 1'b0;
      tx_packet_demand_clock <= 1'b1;
      stuff_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
      tx_payload_strobe <= tick & mode_on; // RULE4 RULE12
      fcs_cmd_d_reg <= fcs_cmd_s;
      if (fcs_cmd_s & ~fcs_cmd_d_reg)
        fcs_hold_reg <= fcs_len; // RULE14
      stuff_reg <= need_stuff & tick;
      // demand clock falls at byte load, rises mid byte; stalls on stuff
      if (byte_done)
        tx_packet_demand_clock <= 1'b0; // RULE15
      else if (tick & ~need_stuff & tx_left_reg == 4'h5)
        tx_packet_demand_clock <= 1'b1; // RULE15
      if (!mode_on) begin
        tx_st_reg <= TX_IDLE;
        tx_ones_reg <= 3'h0;
        tx_payload_bit <= 1'b1;
      end else if (tick) begin
        if (need_stuff) begin
          tx_payload_bit <= 1'b0; // RULE5 RULE16
          tx_ones_reg <= 3'h0;
        end else begin
          tx_payload_bit <= cur_bit; // RULE4
          tx_ones_reg <= (in_frame & cur_bit) ? tx_ones_reg + 3'h1 : 3'h0;
          tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
          tx_left_reg <= tx_left_reg - 4'h1;
          if (byte_done) begin
            tx_left_reg <= 4'h8;
            case (tx_st_reg)
              TX_IDLE, TX_CLOSE: begin
                if (msg_s) begin
                  tx_sh_reg <= txd_s; // RULE3 RULE13
                  tx_st_reg <= TX_DATA;
                end else begin
                  tx_sh_reg <= `FLAG_OCTET; // RULE7 RULE13
                  tx_st_reg <= TX_IDLE;
                end
              end
              TX_DATA: begin
                if (fcs_hold_reg != 3'h0 && fcs_en) begin
                  tx_sh_reg <= ~tx_crc_now[7:0]; // RULE6 RULE17
                  fcs_cnt_reg <= fcs_len - 3'h1;
                  tx_st_reg <= TX_FCS;
                end else if (msg_s) begin
                  tx_sh_reg <= txd_s; // RULE3 RULE13
                end else begin
                  tx_sh_reg <= `FLAG_OCTET;
                  tx_st_reg <= TX_CLOSE;
                end
              end
              TX_FCS: begin
                fcs_hold_reg <= 3'h0;
                if (fcs_cnt_reg != 3'h0) begin
                  tx_sh_reg <= ~tx_crc_byte(tx_crc, fcs_len - fcs_cnt_reg);
                  fcs_cnt_reg <= fcs_cnt_reg - 3'h1;
                end else begin
                  tx_sh_reg <= `FLAG_OCTET; // RULE7
                  tx_st_reg <= TX_CLOSE;
                end
              end
              default: tx_st_reg <= TX_IDLE;
            endcase
          end
        end
      end
    end
  end

  // byte select of the held transmit fcs
  function [7:0] tx_crc_byte;
    input [31:0] c;
    input [2:0] idx;
    begin
      tx_crc_byte = c[8*idx[1:0] +: 8];
    end
  endfunction

  // crc with the bit now on the line folded in
  function [31:0] crc_fold;
    input [31:0] c;
    input b;
    input w;
    begin
      crc_fold = {1'b0, c[31:1]};
      if (c[0] ^ b)
        crc_fold = crc_fold ^ (w ? `CRC32_POLY : {16'h0000, `CRC16_POLY});
      if (!w)
        crc_fold[31:16] = 16'h0000;
    end
  endfunction

  // ------------------------------------------------------------
  // receive deframer
  // ------------------------------------------------------------
  reg rxc_d_reg;
  reg [7:0] rx_win_reg;
  reg [2:0] rx_ones_reg;
  reg [7:0] rx_sh_reg;
  reg [3:0] rx_cnt_reg;
  reg rx_in_frame_reg;
  reg [31:0] rx_pipe_reg;
  reg [2:0] rx_fill_reg;
  reg [31:0] rx_crc_snap_reg;
  wire rx_edge = rxc_s & ~rxc_d_reg & mode_on; // RULE12
  wire [7:0] win_next = {rxd_s, rx_win_reg[7:1]};
  wire is_flag = (win_next == `FLAG_OCTET);
  wire is_abort = rxd_s & (rx_ones_reg == `ABORT_ONES - 3'h1);
  wire is_stuff = ~rxd_s & (rx_ones_reg == `ONES_LIMIT); // RULE11 RULE16
  wire [2:0] rx_lag = crc_wide ? `CRC32_BYTES : `CRC16_BYTES;
  wire [31:0] rx_crc;
  wire [31:0] rx_good = crc_wide ? `CRC32_GOOD : `CRC16_GOOD;
  wire rx_fcs_bad = fcs_en & (rx_crc_snap_reg != rx_good);
  wire bit_take = rx_edge & rx_in_frame_reg & ~is_stuff & ~is_flag;

  fcs_engine u_rx_fcs (
    .clk(clk),
    .rst_n(rst_n),
    .init(rx_edge & is_flag),
    .step(bit_take),
    .din(rxd_s),
    .wide(crc_wide),
    .crc_reg(rx_crc)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_d_reg <= 1'b1;
      rx_win_reg <= 8'h00;
      rx_ones_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      rx_in_frame_reg <= 1'b0;
      rx_pipe_reg <= 32'h00000000;
      rx_fill_reg <= 3'h0;
      rx_crc_snap_reg <= 32'h00000000;
      rx_packet_byte_bus <= 8'h00;
      rx_packet_byte_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_frame_bad <= 1'b0;
      stat_reg <= 4'h0;
    end else begin
      rxc_d_reg <= rxc_s;
      rx_packet_byte_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      stat_reg[`STAT_ACTIVE_BIT] <= mode_on;
      if (rx_edge) begin
        rx_win_reg <= win_next;
        rx_ones_reg <= rxd_s ? ((rx_ones_reg == `ABORT_ONES) ?
          rx_ones_reg : rx_ones_reg + 3'h1) : 3'h0;
        if (is_flag) begin
          // closing flag: fcs check only if a frame was collected
          if (rx_in_frame_reg && rx_fill_reg == rx_lag) begin
            rx_frame_end <= 1'b1;
            rx_frame_bad <= rx_fcs_bad; // RULE10
            stat_reg[`STAT_CRC_ERR_BIT] <= rx_fcs_bad;
            stat_reg[`STAT_FRAME_OK_BIT] <= ~rx_fcs_bad;
          end
          rx_in_frame_reg <= 1'b1; // RULE9
          rx_cnt_reg <= 4'h0;
          rx_fill_reg <= 3'h0;
        end else if (is_abort) begin
          rx_in_frame_reg <= 1'b0;
          stat_reg[`STAT_ABORT_BIT] <= 1'b1;
        end else if (bit_take) begin
          rx_sh_reg <= {rxd_s, rx_sh_reg[7:1]};
          // crc over whole bytes only, before flag bits reach it
          if (rx_cnt_reg == 4'h0)
            rx_crc_snap_reg <= rx_crc; // RULE10
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == 4'h7) begin
            rx_cnt_reg <= 4'h0;
            // hold back trailer bytes so only content is presented
            rx_pipe_reg <= {rx_pipe_reg[23:0], rxd_s, rx_sh_reg[7:1]};
            if (rx_fill_reg == rx_lag) begin
              rx_packet_byte_bus <= crc_wide ? rx_pipe_reg[31:24] :
                rx_pipe_reg[15:8]; // RULE8 RULE11
              rx_packet_byte_valid <= 1'b1; // RULE8
            end else begin
              rx_fill_reg <= rx_fill_reg + 3'h1;
            end
          end
        end
      end
    end
  end
endmodule

/* pkg/packet_mode_defs.vh */
/*
  constants for the byte-wide packet mode: register map, control fields,
  flag and stuffing figures, check-sequence presets and residues.
  assumes inclusion by bare name from the core files.
*/
`ifndef PACKET_MODE_DEFS_VH
`define PACKET_MODE_DEFS_VH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define PKT_CTRL_ADDR 8'h82
`define PKT_STAT_ADDR 8'h83
`define PKT_CTRL_RESET 8'h40
`define PKT_CTRL_ON_BIT 6
`define PKT_CTRL_CRC32_BIT 5
`define PKT_CTRL_FCS_EN_BIT 4

// ------------------------------------------------------------
// status bits
// ------------------------------------------------------------
`define STAT_ACTIVE_BIT 0
`define STAT_CRC_ERR_BIT 1
`define STAT_ABORT_BIT 2
`define STAT_FRAME_OK_BIT 3

// ------------------------------------------------------------
// line constants
// ------------------------------------------------------------
`define FLAG_OCTET 8'h7E
`define ONES_LIMIT 3'h5
`define ABORT_ONES 3'h7
`define BIT_PERIOD 8'h03
`define DEMAND_DIV 4'h8

// ------------------------------------------------------------
// check sequences (reflected forms)
// ------------------------------------------------------------
`define CRC16_POLY 16'h8408
`define CRC32_POLY 32'hEDB88320
`define CRC_PRESET 32'hFFFFFFFF
`define CRC16_GOOD 32'h0000F0B8
`define CRC32_GOOD 32'hDEBB20E3
`define CRC16_BYTES 3'h2
`define CRC32_BYTES 3'h4

`endif

/* core/fcs_engine.v */
/*
  bit-serial frame check sequence for 16 or 32 bits, lsb first.
  assumes one data bit per cycle where step is high, same clock.
*/
`timescale 1ns/100ps
`include "packet_mode_defs.vh"
module fcs_engine (
  input wire clk,
  input wire rst_n,
  input wire init,
  input wire step,
  input wire din,
  input wire wide,
  output reg [31:0] crc_reg
);
  reg [31:0] crc_next;
  reg fb;

  // ------------------------------------------------------------
  // polynomial step
  // ------------------------------------------------------------
  always @* begin
    fb = crc_reg[0] ^ din;
    crc_next = {1'b0, crc_reg[31:1]};
    if (fb) begin
      if (wide)
        crc_next = crc_next ^ `CRC32_POLY; // RULE17
      else
        crc_next = crc_next ^ {16'h0000, `CRC16_POLY}; // RULE17
    end
    if (!wide)
      crc_next[31:16] = 16'h0000;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      crc_reg <= `CRC_PRESET;
    else if (init)
      crc_reg <= wide ? `CRC_PRESET : (`CRC_PRESET >> 16); // RULE17
    else if (step)
      crc_reg <= crc_next;
  end
endmodule

/* core/sync_pair.v */
/*
  two-stage synchroniser for a bundle of level inputs.
  assumes inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
module sync_pair #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* sim/terminal_model.sv */
/*
  terminal side of the transmit byte link: presents bytes on the
  demand clock, then the check-sequence command.
  assumes demand clock comes from the design, sampled on clk.
*/
`timescale 1ns/100ps
module terminal_model #(
  parameter FC = 2
) (
  input wire clk,
  input wire rst_n,
  input wire tx_packet_demand_clock,
  input wire go,
  input wire [3:0] n,
  output reg send_message_cmd,
  output reg send_check_sequence_cmd,
  output reg [7:0] tx_packet_byte_bus
);
  reg [7:0] mem [0:7];
  reg [3:0] idx_reg;
  reg [2:0] fc_reg;
  reg d_reg;
  // ------------------------------------------------------------
  // byte source
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_reg <= 1'b1;
      idx_reg <= 4'h0;
      fc_reg <= 3'h0;
      send_message_cmd <= 1'b0;
      send_check_sequence_cmd <= 1'b0;
      tx_packet_byte_bus <= 8'h00;
    end else begin
      d_reg <= tx_packet_demand_clock;
      if (!go) begin
        idx_reg <= 4'h0;
        fc_reg <= 3'h0;
      end
      // change data on rising demand edge
      if (tx_packet_demand_clock && !d_reg) begin
        if (go && idx_reg < n) begin
          tx_packet_byte_bus <= mem[idx_reg];
          send_message_cmd <= 1'b1;
          idx_reg <= idx_reg + 4'h1;
        end else if (go && fc_reg < FC) begin
          send_check_sequence_cmd <= 1'b1;
          tx_packet_byte_bus <= ~tx_packet_byte_bus;
          fc_reg <= fc_reg + 3'h1;
        end else begin
          send_message_cmd <= 1'b0;
          send_check_sequence_cmd <= 1'b0;
          tx_packet_byte_bus <= ~tx_packet_byte_bus;
        end
      end
    end
  end
endmodule

/* sim/packet_mode_core_monitor.sv */
/*
  port checker for the packet mode core.
  assumes it is bound to packet_mode_core; one clock domain.
*/
`timescale 1ns/100ps
module packet_mode_core_monitor (
  input wire clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire tx_packet_demand_clock,
  input wire tx_payload_bit,
  input wire tx_payload_strobe,
  input wire [7:0] rx_packet_byte_bus,
  input wire rx_packet_byte_valid,
  input wire rx_frame_end
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [2:0] run_reg;
  // ------------------------------------------------------------
  // run of ones on the outbound bits
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) run_reg <= 3'h0;
    else if (tx_payload_strobe) run_reg <= tx_payload_bit ? run_reg + 3'h1 : 3'h0;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_wait_first: assert property ((avs_read || avs_write) &&
    !$past(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait state");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait too long");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address != 8'h82 && avs_address != 8'h83 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_strobe_gap: assert property (tx_payload_strobe |=>
    !tx_payload_strobe [*3] ##1 tx_payload_strobe) else $error("bit pace");
  a_no_abort: assert property (tx_payload_strobe && tx_payload_bit
    |-> run_reg != 3'h6) else $error("seven ones sent");
  a_demand_low: assert property ($fell(tx_packet_demand_clock) |=>
    !tx_packet_demand_clock [*3]) else $error("demand low too short");
  a_rx_pulse: assert property (rx_packet_byte_valid |=>
    !rx_packet_byte_valid) else $error("byte valid too long");
  a_rx_hold: assert property ($changed(rx_packet_byte_bus)
    |-> rx_packet_byte_valid) else $error("byte changed without valid");
  a_end_pulse: assert property (rx_frame_end |=> !rx_frame_end)
    else $error("frame end too long");
endmodule
bind packet_mode_core packet_mode_core_monitor packet_mode_core_monitor_i (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .tx_packet_demand_clock(tx_packet_demand_clock),
  .tx_payload_bit(tx_payload_bit), .tx_payload_strobe(tx_payload_strobe),
  .rx_packet_byte_bus(rx_packet_byte_bus),
  .rx_packet_byte_valid(rx_packet_byte_valid), .rx_frame_end(rx_frame_end));

/* sim/tb_top.sv */
/*
  bench for the packet mode core: register access, transmit framing
  decoded from the payload bits, receive frames sent at 160 ns per bit.
  assumes the terminal model drives the transmit byte link.
*/
`timescale 1ns/100ps
`include "packet_mode_defs.vh"
module tb_top;
  logic clk, rst_n, avs_read, avs_write, rx_payload_bit, rx_payload_clock;
  logic [7:0] avs_address, raw, dsh;
  logic [31:0] avs_writedata, q;
  logic [15:0] c16;
  logic [7:0] td [0:7];
  logic [7:0] dq [$];
  logic [2:0] ones, rones;
  int fails, checked, dn, nflag, rk, nval, nend;
  logic go, txd;
  wire [31:0] avs_readdata;
  wire [7:0] rx_packet_byte_bus, tx_packet_byte_bus;
  wire avs_waitrequest, msg, fcs, dem, tbit, tstb, rvld, rend, rbad;
  packet_mode_core packet_mode_core_i (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nibble_select_strap(1'b1),
    .send_message_cmd(msg), .send_check_sequence_cmd(fcs),
    .tx_packet_byte_bus(tx_packet_byte_bus), .tx_packet_demand_clock(dem),
    .tx_payload_bit(tbit), .tx_payload_strobe(tstb),
    .rx_payload_bit(rx_payload_bit), .rx_payload_clock(rx_payload_clock),
    .rx_packet_byte_bus(rx_packet_byte_bus), .rx_packet_byte_valid(rvld),
    .rx_frame_end(rend), .rx_frame_bad(rbad));
  terminal_model terminal_model_i (.clk(clk), .rst_n(rst_n),
    .tx_packet_demand_clock(dem), .go(go), .n(4'h3),
    .send_message_cmd(msg), .send_check_sequence_cmd(fcs),
    .tx_packet_byte_bus(tx_packet_byte_bus));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task check(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] fcs16(input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++)
      for (int j = 0; j < 8; j++)
        c = (c[0] ^ td[i][j]) ? (c >> 1) ^ `CRC16_POLY : c >> 1;
    return ~c;
  endfunction
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task send_bit(input logic b);
    rx_payload_bit <= b;
    rx_payload_clock <= 1'b0;
    repeat (8) @(posedge clk);
    rx_payload_clock <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task send_byte(input logic [7:0] b, input logic st);
    for (int j = 0; j < 8; j++) begin
      send_bit(b[j]);
      rones = b[j] ? rones + 3'h1 : 3'h0;
      if (st && rones == 3'h5) begin
        send_bit(1'b0);
        rones = 3'h0;
      end
    end
    if (!st) rones = 3'h0;
  endtask
  task send_frame(input logic bad);
    c16 = fcs16(3) ^ {15'h0, bad};
    rk = 0;
    nval = 0;
    nend = 0;
    repeat (3) send_byte(`FLAG_OCTET, 1'b0);
    check("rx_flags_only", nval, 0);
    for (int i = 0; i < 3; i++) send_byte(td[i], 1'b1);
    send_byte(c16[7:0], 1'b1);
    send_byte(c16[15:8], 1'b1);
    send_byte(`FLAG_OCTET, 1'b0);
    rx_payload_bit <= ~rx_payload_bit;
    repeat (8) @(posedge clk);
    check("rx_count", nval, 3);
    check("rx_end", nend, 1);
    check("rx_bad", rbad, {31'h0, bad});
  endtask
  // ------------------------------------------------------------
  // observers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rvld === 1'b1) begin
      check("rx_byte", rx_packet_byte_bus, td[rk]);
      rk++;
      nval++;
    end
    if (rend === 1'b1) nend++;
    if (tstb === 1'b1) begin
      raw = {tbit, raw[7:1]};
      if (raw == `FLAG_OCTET) begin
        nflag++;
        if (dq.size() > 0 && go) begin
          c16 = fcs16(3);
          check("tx_len", dq.size(), 5);
          for (int i = 0; i < 3; i++) check("tx_byte", dq[i], td[i]);
          check("tx_fcs_lo", dq[3], c16[7:0]);
          check("tx_fcs_hi", dq[4], c16[15:8]);
          txd = 1'b1;
        end
        dq.delete();
        dn = 0;
      end else if (!(ones == 3'h5 && !tbit)) begin
        dsh = {tbit, dsh[7:1]};
        dn++;
        if (dn == 8) begin
          dq.push_back(dsh);
          dn = 0;
        end
      end
      ones = tbit ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
    end
  end
  // ------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    finish_test;
  end
  initial begin
    {avs_read, avs_write, go, txd, raw, dsh, ones, rones} = '0;
    {avs_address, avs_writedata, rx_payload_bit} = '0;
    rx_payload_clock = 1'b1;
    td[0] = 8'hFF;
    td[1] = `FLAG_OCTET;
    td[2] = 8'h3C;
    for (int i = 0; i < 3; i++) terminal_model_i.mem[i] = td[i];
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h82, 32'h0);
    check("ctrl_reset", q, 32'h40);
    bus(1'b1, 8'h82, 32'h50);
    bus(1'b1, 8'h90, 32'hFF);
    bus(1'b0, 8'h82, 32'h0);
    check("ctrl_rw", q, 32'h50);
    bus(1'b0, 8'h90, 32'h0);
    check("unmapped", q, 32'h0);
    bus(1'b0, 8'h83, 32'h0);
    check("active", q[0], 1);
    nflag = 0;
    repeat (400) @(posedge clk);
    check("idle_flags", nflag >= 8, 1);
    go <= 1'b1;
    for (int k = 0; k < 4000 && !txd; k++) @(posedge clk);
    check("tx_done", txd, 1);
    go <= 1'b0;
    send_frame(1'b0);
    send_frame(1'b1);
    finish_test;
  end
endmodule
